// [logic/dmc_pkg.sv]
// Constants shared by the mode control register block and its mute ramp.
package dmc_pkg;
   // Frame layout of the 16-bit control word.
   localparam int FRM_RW_BIT     = 15;
   localparam int FRM_IDX_MSB    = 14;
   localparam int FRM_IDX_LSB    = 8;
   localparam int FRM_DATA_MSB   = 7;

   // Register indices.
   localparam logic [6:0] IDX_AUDIO_IF   = 7'h12;
   localparam logic [6:0] IDX_OUT_FILTER = 7'h13;
   localparam logic [6:0] IDX_OP_MODE    = 7'h14;
   localparam logic [6:0] IDX_ZERO_OUT   = 7'h15;
   localparam logic [6:0] IDX_ZERO_FLAG  = 7'h16;

   // Audio interface control fields.
   localparam int AIF_FMT_LSB    = 4;
   localparam int AIF_DMF_LSB    = 2;
   localparam int AIF_DME_BIT    = 1;
   localparam int AIF_MUTE_BIT   = 0;
   localparam logic [7:0] AIF_MASK  = 8'h7f;
   localparam logic [7:0] AIF_RESET = 8'h50;

   // Output filter control fields.
   localparam int OFC_REV_BIT    = 7;
   localparam int OFC_ATS_LSB    = 5;
   localparam int OFC_OPE_BIT    = 4;
   localparam int OFC_BYPASS_STEREO_SEL_BIT   = 2;
   localparam int OFC_FLT_BIT    = 1;
   localparam int OFC_INF_ZERO_MUTE_EN_BIT   = 0;
   localparam logic [7:0] OFC_MASK  = 8'hf7;
   localparam logic [7:0] OFC_RESET = 8'h00;

   // Operating mode control fields.
   localparam int OMC_SOFT_SYSTEM_RESET_BIT   = 6;
   localparam int OMC_STREAM_BIT = 5;
   localparam int OMC_FILTER_THROUGH_BIT   = 4;
   localparam int OMC_MONO_BIT   = 3;
   localparam int OMC_MONO_CHANNEL_SEL_BIT   = 2;
   localparam int OMC_OS_LSB     = 0;
   localparam logic [7:0] OMC_MASK  = 8'h3f;
   localparam logic [7:0] OMC_RESET = 8'h00;

   // Zero output enable fields.
   localparam int ZOE_DZ_LSB     = 1;
   localparam int ZOE_PCM_ZERO_FLAG_EN_BIT   = 0;
   localparam logic [7:0] ZOE_MASK  = 8'h07;
   localparam logic [7:0] ZOE_RESET = 8'h01;

   // De-emphasis rate codes.
   localparam logic [1:0] DMF_OFF    = 2'h0;
   localparam logic [1:0] DMF_48K    = 2'h1;
   localparam logic [1:0] DMF_44K1   = 2'h2;
   localparam logic [1:0] DMF_32K    = 2'h3;

   // Oversampling codes and the multipliers they select.
   localparam logic [1:0] OS_X64     = 2'h0;
   localparam logic [1:0] OS_X32     = 2'h1;
   localparam logic [1:0] OS_X128    = 2'h2;
   localparam logic [7:0] OSR_MUL_64  = 8'h40;
   localparam logic [7:0] OSR_MUL_32  = 8'h20;
   localparam logic [7:0] OSR_MUL_128 = 8'h80;

   // Highest legal audio format code; 110 and 111 are reserved.
   localparam logic [2:0] FMT_LAST_VALID = 3'h5;

   // Soft mute attenuator end points.
   localparam logic [7:0] MUTE_LVL_FULL = 8'hff;
   localparam logic [7:0] MUTE_LVL_OFF  = 8'h00;
endpackage

// [logic/dmc_mute_ramp.sv]
// Soft mute ramp: a 256-step attenuator paced by word clock edges.
`timescale 1ns/10ps
module dmc_mute_ramp
   import dmc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       soft_rst,
   input  wire logic       word_edge,
   input  wire logic [1:0] atten_step_rate,
   input  wire logic       mute_req,
   output logic [7:0]      level_r
);

   logic [2:0] div_r;
   logic [2:0] div_nxt;
   logic [2:0] mask;
   logic [7:0] level_nxt;
   logic       step;

   // Count word clocks; a step fires on every 1st, 2nd, 4th or 8th edge.
   always_comb begin
      unique case (atten_step_rate)
         2'h0: mask = 3'h0;
         2'h1: mask = 3'h1;
         2'h2: mask = 3'h3;
         2'h3: mask = 3'h7;
      endcase
      step = word_edge && ((div_r & mask) == mask);
      div_nxt = word_edge ? div_r + 3'h1 : div_r;
      level_nxt = level_r;
      // Ramp one step at a time so the output only jumps on a hard or soft reset.
      if (step) begin
         if (mute_req && level_r != MUTE_LVL_OFF) begin
            level_nxt = level_r - 8'h01;
         end else if (!mute_req && level_r != MUTE_LVL_FULL) begin
            level_nxt = level_r + 8'h01;
         end
      end
   end

   // Soft reset returns the ramp to full level like a hard reset.
   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         div_r   <= 3'h0;
         level_r <= MUTE_LVL_FULL;
      end else begin
         div_r   <= div_nxt;
         level_r <= level_nxt;
      end
   end

endmodule // dmc_mute_ramp

// [logic/dmc_mode_regs.sv]
// Mode control registers of a stereo audio converter with decoded controls.
`timescale 1ns/10ps
module dmc_mode_regs
   import dmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        frame_valid,
   input  wire logic [15:0] frame_word,
   input  wire logic        word_clock_in,
   input  wire logic        zero_det_left,
   input  wire logic        zero_det_right,
   output logic [7:0]       rd_data_r,
   output logic             rd_valid_r,
   output logic             soft_system_reset_r,
   output logic             deemph_active_r,
   output logic [1:0]       deemph_curve_r,
   output logic [1:0]       fir_perf_sel_r,
   output logic [7:0]       mute_level_r,
   output logic             phase_invert_r,
   output logic             output_disable_r,
   output logic             rolloff_sel_r,
   output logic             inf_zero_hold_r,
   output logic             stream_mode_r,
   output logic             filter_through_r,
   output logic             bypass_stereo_sel_r,
   output logic             mono_mode_r,
   output logic             mono_channel_sel_r,
   output logic [7:0]       osr_multiplier_r,
   output logic [1:0]       stream_bclk_sel_r,
   output logic             osr_reserved_r,
   output logic [2:0]       audio_format_sel_r,
   output logic             format_valid_r,
   output logic [1:0]       bitstream_zero_en_r,
   output logic             pcm_zero_flag_en_r
);

   ////////////////////////////////////////////////////////////////////////
   // Register file and frame decode.

   logic [7:0] aif_r;
   logic [7:0] aif_nxt;
   logic [7:0] ofc_r;
   logic [7:0] ofc_nxt;
   logic [7:0] omc_r;
   logic [7:0] omc_nxt;
   logic [7:0] zoe_r;
   logic [7:0] zoe_nxt;
   logic [7:0] rd_data_nxt;
   logic       rd_valid_nxt;
   logic       soft_system_reset_nxt;
   logic       is_read;
   logic       is_write;
   logic [6:0] idx;
   logic [7:0] wdata;

   // Decode the frame and update the addressed register.
   always_comb begin
      idx      = frame_word[FRM_IDX_MSB:FRM_IDX_LSB];
      wdata    = frame_word[FRM_DATA_MSB:0];
      is_read  = frame_valid && frame_word[FRM_RW_BIT];
      is_write = frame_valid && !frame_word[FRM_RW_BIT];
      aif_nxt  = aif_r;
      ofc_nxt  = ofc_r;
      omc_nxt  = omc_r;
      zoe_nxt  = zoe_r;
      // Only indices 0x12 to 0x15 take writes; 0x16 never does.
      if (is_write) begin
         unique case (idx)
            IDX_AUDIO_IF:   aif_nxt = wdata & AIF_MASK;
            IDX_OUT_FILTER: ofc_nxt = wdata & OFC_MASK;
            // The mask drops the reset bit, so it is never stored.
            IDX_OP_MODE:    omc_nxt = wdata & OMC_MASK;
            IDX_ZERO_OUT:   zoe_nxt = wdata & ZOE_MASK;
            default: ;
         endcase
      end
   end

   // Read answer and soft reset request for the frame of this cycle. A
   // write frame that meets the pulse is lost, so it cannot stretch the pulse.
   always_comb begin
      soft_system_reset_nxt     = is_write && !soft_system_reset_r
                     && (idx == IDX_OP_MODE)
                     && wdata[OMC_SOFT_SYSTEM_RESET_BIT];
      rd_valid_nxt = is_read;
      rd_data_nxt  = 8'h00;
      // Reads answer from stored state; reserved bits come back as zero.
      if (is_read) begin
         unique case (idx)
            IDX_AUDIO_IF:   rd_data_nxt = aif_r;
            IDX_OUT_FILTER: rd_data_nxt = ofc_r;
            IDX_OP_MODE:    rd_data_nxt = omc_r;
            IDX_ZERO_OUT:   rd_data_nxt = zoe_r;
            default:        rd_data_nxt = 8'h00;
         endcase
      end
   end

   // The soft reset pulse also restores every register default.
   always_ff @(posedge clk) begin
      if (reset || soft_system_reset_r) begin
         aif_r <= AIF_RESET;
         ofc_r <= OFC_RESET;
         omc_r <= OMC_RESET;
         zoe_r <= ZOE_RESET;
      end else begin
         aif_r <= aif_nxt;
         ofc_r <= ofc_nxt;
         omc_r <= omc_nxt;
         zoe_r <= zoe_nxt;
      end
   end

   // Read answer and reset pulse; the pulse lasts one cycle by design.
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_r           <= 8'h00;
         rd_valid_r          <= 1'b0;
         soft_system_reset_r <= 1'b0;
      end else begin
         rd_data_r           <= rd_data_nxt;
         rd_valid_r          <= rd_valid_nxt;
         soft_system_reset_r <= soft_system_reset_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Word clock edge and soft mute ramp.

   logic word_prev_r;
   logic word_prev_nxt;
   logic word_edge;

   // Input is synchronous to clk, so a single stage suffices for edges.
   // The stage resets low: a word clock that starts low gives no false
   // step after reset, one that starts high gives a false edge in the first cycle after reset.
   always_comb begin
      word_prev_nxt = word_clock_in;
      word_edge     = word_clock_in && !word_prev_r;
   end

   // Previous level of the word clock.
   always_ff @(posedge clk) begin
      if (reset) begin
         word_prev_r <= 1'b0;
      end else begin
         word_prev_r <= word_prev_nxt;
      end
   end

   dmc_mute_ramp u_ramp (
      .clk             (clk),
      .reset           (reset),
      .soft_rst        (soft_system_reset_r),
      .word_edge       (word_edge),
      .atten_step_rate (ofc_r[OFC_ATS_LSB+1:OFC_ATS_LSB]),
      .mute_req        (aif_r[AIF_MUTE_BIT]),
      .level_r         (mute_level_r)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decoded mode outputs, each registered so ports come from flops.

   logic       stream;
   logic [1:0] deemph_rate_sel;
   logic [1:0] os;
   logic [2:0] fmt;
   logic       deemph_active_nxt;
   logic [1:0] deemph_curve_nxt;
   logic [1:0] fir_perf_sel_nxt;
   logic       inf_zero_hold_nxt;
   logic       mono_channel_sel_nxt;
   logic [7:0] osr_multiplier_nxt;
   logic [1:0] stream_bclk_sel_nxt;
   logic       osr_reserved_nxt;
   logic       format_valid_nxt;
   logic       phase_invert_nxt;
   logic       output_disable_nxt;
   logic       rolloff_sel_nxt;
   logic       bypass_stereo_sel_nxt;
   logic       stream_mode_nxt;
   logic       filter_through_nxt;
   logic       mono_mode_nxt;
   logic [2:0] audio_format_sel_nxt;
   logic [1:0] bitstream_zero_en_nxt;
   logic       pcm_zero_flag_en_nxt;

   // Decode the stored fields; stream mode changes the meaning of two.
   always_comb begin
      stream = omc_r[OMC_STREAM_BIT];
      deemph_rate_sel    = aif_r[AIF_DMF_LSB+1:AIF_DMF_LSB];
      os     = omc_r[OMC_OS_LSB+1:OMC_OS_LSB];
      fmt    = aif_r[AIF_FMT_LSB+2:AIF_FMT_LSB];
      // Rate code 00 disables de-emphasis even when the enable is set.
      deemph_active_nxt = !stream && aif_r[AIF_DME_BIT]
                          && (deemph_rate_sel != DMF_OFF);
      deemph_curve_nxt  = stream ? DMF_OFF : deemph_rate_sel;
      fir_perf_sel_nxt  = stream ? deemph_rate_sel : 2'h0;
      // Hold only while both channels see zero and stream mode is off.
      inf_zero_hold_nxt = ofc_r[OFC_INF_ZERO_MUTE_EN_BIT] && !stream
                          && zero_det_left && zero_det_right;
      mono_channel_sel_nxt = omc_r[OMC_MONO_BIT]
                             && omc_r[OMC_MONO_CHANNEL_SEL_BIT];
      osr_reserved_nxt   = 1'b0;
      osr_multiplier_nxt = OSR_MUL_64;
      unique case (os)
         OS_X64:  osr_multiplier_nxt = OSR_MUL_64;
         OS_X32:  osr_multiplier_nxt = OSR_MUL_32;
         OS_X128: osr_multiplier_nxt = OSR_MUL_128;
         default: osr_reserved_nxt   = 1'b1;
      endcase
      // In stream mode the multiplier is replaced by a bit clock select.
      if (stream) begin
         osr_multiplier_nxt = 8'h00;
      end
      stream_bclk_sel_nxt = stream ? os : 2'h0;
      format_valid_nxt    = (fmt <= FMT_LAST_VALID);
      // Plain copies of single controls; the converter reads them as is.
      phase_invert_nxt      = ofc_r[OFC_REV_BIT];
      output_disable_nxt    = ofc_r[OFC_OPE_BIT];
      rolloff_sel_nxt       = ofc_r[OFC_FLT_BIT];
      bypass_stereo_sel_nxt = ofc_r[OFC_BYPASS_STEREO_SEL_BIT];
      stream_mode_nxt       = stream;
      filter_through_nxt    = omc_r[OMC_FILTER_THROUGH_BIT];
      mono_mode_nxt         = omc_r[OMC_MONO_BIT];
      audio_format_sel_nxt  = fmt;
      bitstream_zero_en_nxt = zoe_r[ZOE_DZ_LSB+1:ZOE_DZ_LSB];
      pcm_zero_flag_en_nxt  = zoe_r[ZOE_PCM_ZERO_FLAG_EN_BIT];
   end

   // Register every decoded output; ports lag the stored fields by one.
   always_ff @(posedge clk) begin
      if (reset) begin
         deemph_active_r     <= 1'b0;
         deemph_curve_r      <= DMF_OFF;
         fir_perf_sel_r      <= 2'h0;
         phase_invert_r      <= 1'b0;
         output_disable_r    <= 1'b0;
         rolloff_sel_r       <= 1'b0;
         inf_zero_hold_r     <= 1'b0;
         stream_mode_r       <= 1'b0;
         filter_through_r    <= 1'b0;
         bypass_stereo_sel_r <= 1'b0;
         mono_mode_r         <= 1'b0;
         mono_channel_sel_r  <= 1'b0;
         osr_multiplier_r    <= OSR_MUL_64;
         stream_bclk_sel_r   <= 2'h0;
         osr_reserved_r      <= 1'b0;
         audio_format_sel_r  <= AIF_RESET[AIF_FMT_LSB+2:AIF_FMT_LSB];
         format_valid_r      <= 1'b1;
         bitstream_zero_en_r <= 2'h0;
         pcm_zero_flag_en_r  <= ZOE_RESET[ZOE_PCM_ZERO_FLAG_EN_BIT];
      end else begin
         deemph_active_r     <= deemph_active_nxt;
         deemph_curve_r      <= deemph_curve_nxt;
         fir_perf_sel_r      <= fir_perf_sel_nxt;
         phase_invert_r      <= phase_invert_nxt;
         output_disable_r    <= output_disable_nxt;
         rolloff_sel_r       <= rolloff_sel_nxt;
         inf_zero_hold_r     <= inf_zero_hold_nxt;
         stream_mode_r       <= stream_mode_nxt;
         filter_through_r    <= filter_through_nxt;
         bypass_stereo_sel_r <= bypass_stereo_sel_nxt;
         mono_mode_r         <= mono_mode_nxt;
         mono_channel_sel_r  <= mono_channel_sel_nxt;
         osr_multiplier_r    <= osr_multiplier_nxt;
         stream_bclk_sel_r   <= stream_bclk_sel_nxt;
         osr_reserved_r      <= osr_reserved_nxt;
         audio_format_sel_r  <= audio_format_sel_nxt;
         format_valid_r      <= format_valid_nxt;
         bitstream_zero_en_r <= bitstream_zero_en_nxt;
         pcm_zero_flag_en_r  <= pcm_zero_flag_en_nxt;
      end
   end

endmodule // dmc_mode_regs

// [sim/dmc_host.sv]
// Host model that sends control frames and collects read answers.
`timescale 1ns/10ps
module dmc_host (
   input  wire logic        clk,
   input  wire logic        rd_valid_r,
   input  wire logic [7:0]  rd_data_r,
   output logic             frame_valid,
   output logic [15:0]      frame_word
);
   // The host starts idle.
   initial begin
      frame_valid = 1'b0;
      frame_word  = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // One frame per call, entered at a falling edge; hold keeps the strobe
   // up so the next call makes a back-to-back frame. An idle word is
   // scrambled so that stale data can never pass for a live frame.
   task automatic send(input logic [15:0] w, input bit hold);
      frame_valid = 1'b1;
      frame_word  = w;
      @(negedge clk);
      if (!hold) begin
         frame_valid = 1'b0;
         frame_word  = ~w;
      end
   endtask

   // A read frame, then a bounded wait for the one-cycle answer. One more
   // edge passes before return, so the next frame never raises the strobe
   // in the time step that lowered it.
   task automatic rd(input logic [6:0] idx, output logic [7:0] d,
                     output bit ok);
      ok          = 1'b0;
      d           = 8'h00;
      frame_valid = 1'b1;
      frame_word  = {1'b1, idx, 8'h00};
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge clk);
         frame_valid = 1'b0;
         frame_word  = {1'b0, ~idx, 8'hff};
         if (rd_valid_r === 1'b1) begin
            ok = 1'b1;
            d  = rd_data_r;
         end
      end
      @(negedge clk);
   endtask
endmodule // dmc_host

// [sim/dmc_mode_regs_checker.sv]
// Concurrent checks on the ports of the mode control register block.
`timescale 1ns/10ps
module dmc_mode_regs_checker
   import dmc_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        frame_valid,
   input wire logic [15:0] frame_word,
   input wire logic        zero_det_left,
   input wire logic        zero_det_right,
   input wire logic        rd_valid_r,
   input wire logic        soft_system_reset_r,
   input wire logic        deemph_active_r,
   input wire logic [1:0]  deemph_curve_r,
   input wire logic [1:0]  fir_perf_sel_r,
   input wire logic [7:0]  mute_level_r,
   input wire logic        phase_invert_r,
   input wire logic        inf_zero_hold_r,
   input wire logic        stream_mode_r,
   input wire logic        mono_mode_r,
   input wire logic        mono_channel_sel_r,
   input wire logic [2:0]  audio_format_sel_r,
   input wire logic        format_valid_r
);
   // One clock domain, so clocking and disable are declared once.
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////
   // A write frame taken while the soft reset pulse stands is lost, hence the
   // pulse term in the write frame antecedents.
   a_read_answer: assert property (
      frame_valid && frame_word[15] && !soft_system_reset_r |=> rd_valid_r)
      else $error("read frame got no answer");
   a_read_cause: assert property (
      rd_valid_r |-> $past(frame_valid && frame_word[15]))
      else $error("read answer without a read frame");
   a_soft_system_reset_pulse: assert property (
      frame_valid && !frame_word[15] && frame_word[14:8] == IDX_OP_MODE &&
      frame_word[6] && !soft_system_reset_r
      |=> soft_system_reset_r ##1 !soft_system_reset_r)
      else $error("soft reset pulse not one cycle");
   a_phase_write: assert property (
      frame_valid && !frame_word[15] && !soft_system_reset_r &&
      frame_word[14:8] == IDX_OUT_FILTER
      |-> ##2 phase_invert_r == $past(frame_word[7], 2))
      else $error("phase invert does not follow write");
   a_mono_channel_sel_mono: assert property (
      mono_channel_sel_r |-> mono_mode_r)
      else $error("channel select active outside mono");
   a_zero_hold: assert property (
      inf_zero_hold_r |-> !stream_mode_r &&
      $past(zero_det_left && zero_det_right))
      else $error("zero hold without cause");
   a_deemph_map: assert property (
      deemph_active_r |-> deemph_curve_r != DMF_OFF && !stream_mode_r)
      else $error("de-emphasis active with no curve");
   a_fir_stream: assert property (
      fir_perf_sel_r != 2'h0 |-> stream_mode_r && deemph_curve_r == 2'h0)
      else $error("filter select outside stream mode");
   a_mute_step: assert property (
      $changed(mute_level_r) |->
      mute_level_r == $past(mute_level_r) - 8'h01 ||
      mute_level_r == $past(mute_level_r) + 8'h01 ||
      $past(soft_system_reset_r))
      else $error("mute level jumped by more than one step");
   a_format_valid: assert property (
      format_valid_r == (audio_format_sel_r <= FMT_LAST_VALID))
      else $error("format valid flag wrong");
endmodule // dmc_mode_regs_checker

bind dmc_mode_regs dmc_mode_regs_checker chk (.*);

// [sim/dmc_mode_regs_tb.sv]
// Self-checking bench for the mode control register block.
`timescale 1ns/10ps
module dmc_mode_regs_tb
   import dmc_pkg::*;
;
   logic        clk, reset, frame_valid, word_clock_in;
   logic        zero_det_left, zero_det_right, rd_valid_r;
   logic        soft_system_reset_r, deemph_active_r, phase_invert_r;
   logic        output_disable_r, rolloff_sel_r, inf_zero_hold_r;
   logic        stream_mode_r, filter_through_r, bypass_stereo_sel_r;
   logic        mono_mode_r, mono_channel_sel_r, osr_reserved_r;
   logic        format_valid_r, pcm_zero_flag_en_r;
   logic [1:0]  deemph_curve_r, fir_perf_sel_r, stream_bclk_sel_r;
   logic [1:0]  bitstream_zero_en_r;
   logic [2:0]  audio_format_sel_r;
   logic [7:0]  rd_data_r, mute_level_r, osr_multiplier_r;
   logic [15:0] frame_word;
   int          failures, total_checks;

   dmc_mode_regs dut (.*);
   dmc_host host (.*);

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // A write, then one more edge so the decoded outputs have landed.
   task automatic wr(input logic [15:0] w);
      host.send(w, 1'b0);
      @(negedge clk);
   endtask

   // A read that never answers ends the run at once.
   task automatic rdc(input logic [6:0] i, input logic [7:0] e);
      logic [7:0] d;
      bit         ok;
      host.rd(i, d, ok);
      if (!ok) begin
         failures++;
         summarize();
      end
      chk("read data", e, d);
   endtask

   // Word clock rising edges, one every two system clocks.
   task automatic edges(input int n);
      repeat (n) begin
         word_clock_in = 1'b1;
         @(negedge clk);
         word_clock_in = 1'b0;
         @(negedge clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(IDX_AUDIO_IF, AIF_RESET);
      rdc(IDX_OUT_FILTER, 8'h00);
      rdc(IDX_OP_MODE, 8'h00);
      rdc(IDX_ZERO_OUT, 8'h01);
      chk("osr", OSR_MUL_64, osr_multiplier_r);
      chk("mute", MUTE_LVL_FULL, mute_level_r);
      chk("fmt", 8'h05, {5'h0, audio_format_sel_r});
      chk("fmt ok", 8'h01, {7'h0, format_valid_r});
   endtask

   task automatic t_regs();
      wr(16'h15ff);
      rdc(IDX_ZERO_OUT, 8'h07);
      chk("zero en", 8'h07,
          {5'h0, bitstream_zero_en_r, pcm_zero_flag_en_r});
      wr(16'h16ff);
      rdc(IDX_ZERO_FLAG, 8'h00);
      wr(16'h10ff);
      rdc(7'h10, 8'h00);
      rdc(7'h7f, 8'h00);
      wr(16'h13ff);
      rdc(IDX_OUT_FILTER, 8'hf7);
      chk("ofc", 8'h0f, {4'h0, phase_invert_r, output_disable_r,
          rolloff_sel_r, bypass_stereo_sel_r});
      wr(16'h12f2);
      rdc(IDX_AUDIO_IF, 8'h72);
      chk("fmt ok", 8'h00, {7'h0, format_valid_r});
      chk("fmt", 8'h07, {5'h0, audio_format_sel_r});
   endtask

   task automatic t_modes();
      logic [7:0] m [4] = '{OSR_MUL_64, OSR_MUL_32, OSR_MUL_128, OSR_MUL_64};
      for (int c = 0; c < 4; c++) begin
         wr({8'h12, 8'h52 | 8'(c << 2)});
         chk("deemph", {7'h0, c != 0}, {7'h0, deemph_active_r});
         chk("curve", 8'(c), {6'h0, deemph_curve_r});
         wr({8'h14, 8'(c)});
         chk("osr", m[c], osr_multiplier_r);
         chk("osr rsv", {7'h0, c == 3}, {7'h0, osr_reserved_r});
      end
      wr(16'h1436);
      chk("stream", 8'h32, {2'h0, stream_mode_r, filter_through_r, 1'b0,
          mono_channel_sel_r, stream_bclk_sel_r});
      chk("fir", 8'h03, {deemph_active_r, 5'h0, fir_perf_sel_r});
      chk("osr", 8'h00, osr_multiplier_r);
      wr(16'h140c);
      chk("mono", 8'h0c, {4'h0, mono_mode_r, mono_channel_sel_r,
          stream_bclk_sel_r});
   endtask

   // Zero hold needs both channels, and stream mode overrides it.
   task automatic t_izm();
      wr(16'h1301);
      zero_det_left = 1'b1;
      repeat (2) @(negedge clk);
      chk("zero hold", 8'h00, {7'h0, inf_zero_hold_r});
      zero_det_right = 1'b1;
      repeat (2) @(negedge clk);
      chk("zero hold", 8'h01, {7'h0, inf_zero_hold_r});
      wr(16'h1420);
      chk("zero hold", 8'h00, {7'h0, inf_zero_hold_r});
   endtask

   // Sixteen word edges give 8 steps at rate 01 and 2 steps at rate 11;
   // after unmute, 4 edges at rate 00 give 4 steps and 8 at rate 10 give 2.
   task automatic t_mute();
      wr(16'h1320);
      wr(16'h1251);
      edges(16);
      chk("ramp", 8'hf7, mute_level_r);
      wr(16'h1360);
      edges(16);
      chk("ramp", 8'hf5, mute_level_r);
      wr(16'h1300);
      wr(16'h1250);
      edges(4);
      chk("ramp", 8'hf9, mute_level_r);
      wr(16'h1340);
      edges(8);
      chk("ramp", 8'hfb, mute_level_r);
   endtask

   // The frame right after the soft reset write must be lost.
   task automatic t_soft_system_reset();
      host.send(16'h1440, 1'b1);
      chk("pulse", 8'h01, {7'h0, soft_system_reset_r});
      host.send(16'h13ff, 1'b0);
      chk("pulse", 8'h00, {7'h0, soft_system_reset_r});
      rdc(IDX_OUT_FILTER, 8'h00);
      rdc(IDX_OP_MODE, 8'h00);
      chk("mute", MUTE_LVL_FULL, mute_level_r);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Main sequence, all inputs changed at falling edges.
   initial begin
      reset          = 1'b1;
      word_clock_in  = 1'b0;
      zero_det_left  = 1'b0;
      zero_det_right = 1'b0;
      failures       = 0;
      total_checks   = 0;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      t_reset();
      t_regs();
      t_modes();
      t_izm();
      t_mute();
      t_soft_system_reset();
      summarize();
   end
endmodule // dmc_mode_regs_tb
